// ---- verilog/dfa_pkg.sv ----
// dfa_pkg: register map, field positions, limits and timing for the
// drive frequency auxiliary control block.
// assumes a 20 MHz system clock and a 32-bit classic Wishbone master.
package dfa_pkg;
  // -----------------------------------------------------------------
  // register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_SETF   = 8'h08;
  localparam logic [7:0] OFS_DEAD   = 8'h0C;
  localparam logic [7:0] OFS_CARR   = 8'h10;
  localparam logic [7:0] OFS_INCHF  = 8'h14;
  localparam logic [7:0] OFS_INCHA  = 8'h18;
  localparam logic [7:0] OFS_INCHD  = 8'h1C;
  localparam logic [7:0] OFS_SKIP1  = 8'h20;
  localparam logic [7:0] OFS_SKIP2  = 8'h24;
  localparam logic [7:0] OFS_SKAMP  = 8'h28;
  localparam logic [7:0] OFS_STAT   = 8'h2C;
  localparam logic [7:0] OFS_TGT    = 8'h30;
  localparam logic [7:0] OFS_CEFF   = 8'h34;
  // -----------------------------------------------------------------
  // control and status fields
  // -----------------------------------------------------------------
  localparam int CB_RET   = 0;
  localparam int CB_THADJ = 1;
  localparam int CB_LOCK  = 2;
  localparam int CB_PRIO  = 3;
  localparam int CB_SKR   = 4;
  localparam int CB_RES   = 5;
  localparam int SB_RUN   = 0;
  localparam int SB_REV   = 1;
  localparam int SB_DZ    = 2;
  localparam int SB_INCH  = 3;
  localparam int SB_LOCK  = 4;
  localparam int SB_HOT   = 5;
  // -----------------------------------------------------------------
  // codes, limits and reset values
  // -----------------------------------------------------------------
  localparam logic [1:0]  RES_TENTH  = 2'h1;
  localparam logic [1:0]  RES_HUND   = 2'h2;
  localparam logic [7:0]  CARR_MIN   = 8'h05;
  localparam logic [7:0]  CARR_MAX   = 8'hA0;
  localparam logic [7:0]  CARR_DEF   = 8'h28;
  localparam logic [15:0] FREQ_CAP   = 16'h7D00;
  localparam logic [15:0] DEAD_MAX   = 16'h7530;
  localparam logic [15:0] INCH_T_MAX = 16'hFDE8;
  localparam logic [15:0] INCH_F_RST = 16'h00C8;
  localparam logic [15:0] INCH_T_RST = 16'h00C8;
  // -----------------------------------------------------------------
  // timing: one dead-time step is 0.1 s
  // -----------------------------------------------------------------
  localparam int TICK_NS     = 100_000_000;
  localparam int CLK_NS      = 50;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
endpackage

// ---- verilog/dfa_core.sv ----
// dfa_core: frequency reference and run command conditioning.
// assumes ramp generator and command logic share clk_i; run, reverse,
// inch and heat-sink inputs are pins and are synchronised here.
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dfa_core #(
  parameter int unsigned TICK_CYCLES = dfa_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins
  input  wire logic        run_cmd_i,
  input  wire logic        reverse_cmd_i,
  input  wire logic        inch_cmd_i,
  input  wire logic        heat_high_i,
  // drive control logic
  input  wire logic        fault_reset_i,
  input  wire logic        digital_src_i,
  input  wire logic        drive_stopped_i,
  input  wire logic        ramp_active_i,
  input  wire logic        ramp_up_i,
  input  wire logic [15:0] ramp_freq_i,
  // toward modulation and ramp generator
  output logic             run_o,
  output logic             reverse_o,
  output logic             zero_hold_o,
  output logic             inch_active_o,
  output logic             direct_start_o,
  output logic             decel_stop_o,
  output logic      [15:0] target_freq_o,
  output logic      [15:0] running_freq_o,
  output logic      [15:0] inch_accel_o,
  output logic      [15:0] inch_decel_o,
  output logic      [7:0]  carrier_rate_o,
  output logic      [1:0]  freq_res_o
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic        run_s1, run_s2, dir_s1, dir_s2;
    logic        inch_s1, inch_s2, heat_s1, heat_s2;
    logic        lock, stop_prev, ack, dz, dir, inch_act, run_out;
    logic        ret, thadj, lock_en, prio, skr;
    logic [1:0]  res;
    logic [15:0] preset, set_f, dead_t, inch_f, inch_acc, inch_dec;
    logic [15:0] sk1, sk2, skamp, tgt, run_f;
    logic [7:0]  carrier, car_eff;
    logic [20:0] pre;
    logic [15:0] dcnt;
    logic [31:0] rdata;
  } dfa_state_t;

  // run sync starts high so the lock cannot clear before real data
  localparam dfa_state_t RST = '{
    run_s1: 1'b1, run_s2: 1'b1, lock: 1'b1, thadj: 1'b1, stop_prev: 1'b1,
    res: dfa_pkg::RES_HUND, inch_f: dfa_pkg::INCH_F_RST,
    inch_acc: dfa_pkg::INCH_T_RST, inch_dec: dfa_pkg::INCH_T_RST,
    carrier: dfa_pkg::CARR_DEF, car_eff: dfa_pkg::CARR_DEF,
    default: '0};
  localparam logic [20:0] PRE_LAST = 21'(TICK_CYCLES - 1);

  dfa_state_t q;
  dfa_state_t d;
  logic       acc;
  logic       run_ok;
  logic       stop_rise;
  logic       tick;
  logic [7:0] half_car;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] dat,
                                       input logic [3:0]  sel);
    wr16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction
  function automatic logic [15:0] lim16(input logic [15:0] v, input logic [15:0] mx);
    lim16 = (v > mx) ? mx : v;
  endfunction
  function automatic logic [15:0] band_lo(input logic [15:0] j, input logic [15:0] a);
    band_lo = (j > a) ? j - a : 16'h0000;
  endfunction
  function automatic logic [15:0] band_hi(input logic [15:0] j, input logic [15:0] a);
    logic [16:0] s;
    s = {1'b0, j} + {1'b0, a};
    band_hi = s[16] ? 16'hFFFF : s[15:0];
  endfunction
  // strictly inside a band; edges are legal running points
  function automatic logic in_band(input logic [15:0] f, input logic [15:0] j,
                                   input logic [15:0] a);
    in_band = (f > band_lo(j, a)) && (f < band_hi(j, a));
  endfunction
  // mode 0: nearest edge, 1: upper edge, 2: lower edge
  function automatic logic [15:0] skip(input logic [15:0] f, input logic [15:0] j1,
                                       input logic [15:0] j2, input logic [15:0] a,
                                       input logic [1:0]  mode);
    logic [15:0] r;
    logic [15:0] lo;
    logic [15:0] hi;
    r = f;
    if ((j1 | j2) != 16'h0000) begin
      for (int i = 0; i < 2; i++) begin
        lo = band_lo(i == 0 ? j1 : j2, a);
        hi = band_hi(i == 0 ? j1 : j2, a);
        if (r > lo && r < hi) begin
          case (mode)
            2'h1:    r = hi;
            2'h2:    r = lo;
            default: r = ((r - lo) <= (hi - r)) ? lo : hi;
          endcase
        end
      end
    end
    skip = r;
  endfunction

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  assign acc       = wb_cyc_i && wb_stb_i && !q.ack;
  assign run_ok    = q.run_s2 && !(q.lock_en && q.lock);
  assign stop_rise = drive_stopped_i && !q.stop_prev;
  assign tick      = (q.pre == PRE_LAST);
  assign half_car  = {1'b0, q.carrier[7:1]};

  always_comb begin
    d           = q;
    d.run_s1    = run_cmd_i;
    d.run_s2    = q.run_s1;
    d.dir_s1    = reverse_cmd_i;
    d.dir_s2    = q.dir_s1;
    d.inch_s1   = inch_cmd_i;
    d.inch_s2   = q.inch_s1;
    d.heat_s1   = heat_high_i;
    d.heat_s2   = q.heat_s1;
    d.stop_prev = drive_stopped_i;
    d.ack       = acc;
    // lock clears on a withdrawn command; a fault reset sets it only while the command is held
    if (!q.run_s2) begin
      d.lock = 1'b0;
    end
    if (fault_reset_i && q.run_s2) begin
      d.lock = 1'b1;
    end
    // inch from standstill always, during a run only with priority
    d.inch_act = q.inch_s2 && (!run_ok || q.prio || q.inch_act);
    d.run_out  = run_ok || d.inch_act;
    // reversal dead zone, counted in 0.1 s steps
    d.pre = (q.dz && !tick) ? q.pre + 21'h000001 : 21'h000000;
    if (q.dz) begin
      if (tick) begin
        if (q.dcnt == 16'h0000) begin
          d.dz  = 1'b0;
          d.dir = q.dir_s2;
        end else begin
          d.dcnt = q.dcnt - 16'h0001;
        end
      end
    end else if (q.dir_s2 != q.dir) begin
      if (q.run_out && q.dead_t != 16'h0000) begin
        d.dz   = 1'b1;
        d.dcnt = q.dead_t - 16'h0001;
      end else begin
        d.dir = q.dir_s2;
      end
    end
    // thermal fallback halves the carrier, never below minimum
    if (q.thadj && q.heat_s2) begin
      d.car_eff = (half_car < dfa_pkg::CARR_MIN) ? dfa_pkg::CARR_MIN
                                                  : half_car;
    end else begin
      d.car_eff = q.carrier;
    end
    // register writes
    if (acc && wb_we_i) begin
      case (wb_adr_i)
        dfa_pkg::OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            d.ret     = wb_dat_i[dfa_pkg::CB_RET];
            d.thadj   = wb_dat_i[dfa_pkg::CB_THADJ];
            d.lock_en = wb_dat_i[dfa_pkg::CB_LOCK];
            d.prio    = wb_dat_i[dfa_pkg::CB_PRIO];
            d.skr     = wb_dat_i[dfa_pkg::CB_SKR];
            if (wb_dat_i[dfa_pkg::CB_RES+:2] == dfa_pkg::RES_TENTH ||
                wb_dat_i[dfa_pkg::CB_RES+:2] == dfa_pkg::RES_HUND) begin
              d.res = wb_dat_i[dfa_pkg::CB_RES+:2];
            end
          end
        end
        dfa_pkg::OFS_PRESET: d.preset = lim16(wr16(q.preset, wb_dat_i, wb_sel_i),
                                              dfa_pkg::FREQ_CAP);
        dfa_pkg::OFS_SETF:   d.set_f = lim16(wr16(q.set_f, wb_dat_i, wb_sel_i),
                                             dfa_pkg::FREQ_CAP);
        dfa_pkg::OFS_DEAD:   d.dead_t = lim16(wr16(q.dead_t, wb_dat_i, wb_sel_i),
                                              dfa_pkg::DEAD_MAX);
        dfa_pkg::OFS_CARR: begin
          if (wb_sel_i[0] && wb_dat_i[7:0] >= dfa_pkg::CARR_MIN &&
              wb_dat_i[7:0] <= dfa_pkg::CARR_MAX) begin
            d.carrier = wb_dat_i[7:0];
          end
        end
        dfa_pkg::OFS_INCHF: d.inch_f = lim16(wr16(q.inch_f, wb_dat_i, wb_sel_i),
                                             dfa_pkg::FREQ_CAP);
        dfa_pkg::OFS_INCHA: d.inch_acc = lim16(wr16(q.inch_acc, wb_dat_i, wb_sel_i),
                                               dfa_pkg::INCH_T_MAX);
        dfa_pkg::OFS_INCHD: d.inch_dec = lim16(wr16(q.inch_dec, wb_dat_i, wb_sel_i),
                                               dfa_pkg::INCH_T_MAX);
        dfa_pkg::OFS_SKIP1: d.sk1 = lim16(wr16(q.sk1, wb_dat_i, wb_sel_i), dfa_pkg::FREQ_CAP);
        dfa_pkg::OFS_SKIP2: d.sk2 = lim16(wr16(q.sk2, wb_dat_i, wb_sel_i), dfa_pkg::FREQ_CAP);
        dfa_pkg::OFS_SKAMP: d.skamp = lim16(wr16(q.skamp, wb_dat_i, wb_sel_i),
                                            dfa_pkg::FREQ_CAP);
        default: ;
      endcase
    end
    // stop restore comes after writes so it wins a collision
    if (stop_rise && digital_src_i && !q.ret) begin
      d.set_f = q.preset;
    end
    // with retention the stop leaves set_f untouched
    // target reference toward the ramp generator
    if (q.dz) begin
      d.tgt = 16'h0000;
    end else if (q.inch_act) begin
      d.tgt = q.inch_f;
    end else begin
      d.tgt = lim16(skip(q.set_f, q.sk1, q.sk2, q.skamp, 2'h0),
                    dfa_pkg::FREQ_CAP);
    end
    // running frequency jumps a band while ramping
    if (q.skr && ramp_active_i) begin
      d.run_f = skip(ramp_freq_i, q.sk1, q.sk2, q.skamp,
                     ramp_up_i ? 2'h1 : 2'h2);
    end else begin
      d.run_f = ramp_freq_i;
    end
    // read data latched with ack; unmapped reads return zero
    d.rdata = 32'h00000000;
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        dfa_pkg::OFS_CTRL: begin
          d.rdata[dfa_pkg::CB_RET]     = q.ret;
          d.rdata[dfa_pkg::CB_THADJ]   = q.thadj;
          d.rdata[dfa_pkg::CB_LOCK]    = q.lock_en;
          d.rdata[dfa_pkg::CB_PRIO]    = q.prio;
          d.rdata[dfa_pkg::CB_SKR]     = q.skr;
          d.rdata[dfa_pkg::CB_RES+:2]  = q.res;
        end
        dfa_pkg::OFS_PRESET: d.rdata[15:0] = q.preset;
        dfa_pkg::OFS_SETF:   d.rdata[15:0] = q.set_f;
        dfa_pkg::OFS_DEAD:   d.rdata[15:0] = q.dead_t;
        dfa_pkg::OFS_CARR:   d.rdata[7:0]  = q.carrier;
        dfa_pkg::OFS_INCHF:  d.rdata[15:0] = q.inch_f;
        dfa_pkg::OFS_INCHA:  d.rdata[15:0] = q.inch_acc;
        dfa_pkg::OFS_INCHD:  d.rdata[15:0] = q.inch_dec;
        dfa_pkg::OFS_SKIP1:  d.rdata[15:0] = q.sk1;
        dfa_pkg::OFS_SKIP2:  d.rdata[15:0] = q.sk2;
        dfa_pkg::OFS_SKAMP:  d.rdata[15:0] = q.skamp;
        dfa_pkg::OFS_STAT: begin
          d.rdata[dfa_pkg::SB_RUN]  = q.run_out;
          d.rdata[dfa_pkg::SB_REV]  = q.dir;
          d.rdata[dfa_pkg::SB_DZ]   = q.dz;
          d.rdata[dfa_pkg::SB_INCH] = q.inch_act;
          d.rdata[dfa_pkg::SB_LOCK] = q.lock_en && q.lock;
          d.rdata[dfa_pkg::SB_HOT]  = q.thadj && q.heat_s2;
        end
        dfa_pkg::OFS_TGT:    d.rdata[15:0] = q.tgt;
        dfa_pkg::OFS_CEFF:   d.rdata[7:0]  = q.car_eff;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign wb_ack_o       = q.ack;
  assign wb_dat_o       = q.rdata;
  assign run_o          = q.run_out;
  assign reverse_o      = q.dir;
  assign zero_hold_o    = q.dz;
  assign inch_active_o  = q.inch_act;
  assign direct_start_o = q.inch_act;
  assign decel_stop_o   = q.inch_act;
  assign target_freq_o  = q.tgt;
  assign running_freq_o = q.run_f;
  assign inch_accel_o   = q.inch_acc;
  assign inch_decel_o   = q.inch_dec;
  assign carrier_rate_o = q.car_eff;
  assign freq_res_o     = q.res;

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_locked_idle;
    q.lock_en && q.lock && !q.run_s2 && !fault_reset_i;
  endsequence
  sequence s_cmd_back;
    q.run_s2 && !fault_reset_i;
  endsequence

  a_lock_blocks: assert property (q.lock_en && q.lock |=> q.run_out == q.inch_act)
    else $error("run passed while locked");
  a_rearm_runs: assert property (s_locked_idle ##1 s_cmd_back |=> q.run_out)
    else $error("reasserted run not accepted");
  a_fault_lock: assert property (fault_reset_i && q.run_s2 |=> q.lock)
    else $error("fault reset did not relock");
  a_dead_zero: assert property (q.dz |=> q.tgt == 16'h0000)
    else $error("output not zero in dead zone");
  a_carr_range: assert property (q.carrier >= dfa_pkg::CARR_MIN &&
                                 q.carrier <= dfa_pkg::CARR_MAX)
    else $error("carrier outside range");
  a_hot_lower: assert property (q.thadj && q.heat_s2 |=>
      q.car_eff < $past(q.carrier) || q.car_eff == dfa_pkg::CARR_MIN)
    else $error("carrier not lowered when hot");
  a_cool_restore: assert property (!q.heat_s2 |=> q.car_eff == $past(q.carrier))
    else $error("carrier not restored");
  a_preset_back: assert property (stop_rise && digital_src_i && !q.ret |=>
      q.set_f == $past(q.preset))
    else $error("set frequency not restored");
  a_setf_kept: assert property (stop_rise && (q.ret || !digital_src_i) &&
      !(acc && wb_we_i) |=> $stable(q.set_f))
    else $error("set frequency changed at stop");
  a_inch_target: assert property (q.inch_act && !q.dz |=> q.tgt == $past(q.inch_f))
    else $error("inch target wrong");
  a_inch_prio: assert property (q.prio && run_ok && q.inch_s2 |=> q.inch_act)
    else $error("inch priority ignored");
  a_skip_clear: assert property (!q.dz && !q.inch_act |=>
      !in_band(q.tgt, $past(q.sk1), $past(q.skamp)) ||
      ($past(q.sk1) | $past(q.sk2)) == 16'h0000)
    else $error("target inside skip band");
  a_freq_cap: assert property (q.tgt <= dfa_pkg::FREQ_CAP)
    else $error("target above cap");
endmodule

// ---- verification/dfa_ramp_model.sv ----
// dfa_ramp_model: ramp generator and modulation stage facing dfa_core.
// assumes the core's clock and reset; moves one step per cycle.
`timescale 1ns/1ps
module dfa_ramp_model #(
  parameter logic [15:0] STEP = 16'h0040
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // from the core
  input  wire logic        run_i,
  input  wire logic        slow_i,
  input  wire logic [15:0] target_i,
  // back to the core
  output logic             stopped_o,
  output logic             active_o,
  output logic             up_o,
  output logic      [15:0] freq_o
);
  logic [15:0] goal;
  logic [15:0] st;
  assign goal = run_i ? target_i : 16'h0000;
  // slow mode: quarter step, a long ramp through the bands
  assign st = slow_i ? (STEP >> 2) : STEP;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      freq_o    <= 16'h0000;
      active_o  <= 1'b0;
      up_o      <= 1'b0;
      stopped_o <= 1'b1;
    end else begin
      active_o  <= freq_o != goal;
      up_o      <= freq_o < goal;
      stopped_o <= !run_i && freq_o == 16'h0000;
      if (freq_o + st < goal) freq_o <= freq_o + st;
      else if (freq_o > goal + st) freq_o <= freq_o - st;
      else freq_o <= goal;
    end
  end
endmodule

// ---- verification/dfa_core_tb_top.sv ----
// dfa_core_tb_top: self-checking bench, register and band model in ints.
// assumes dfa_ramp_model as far side and a shortened dead-time tick.
`timescale 1ns/1ps
module dfa_core_tb_top;
  localparam int TK = 4;
  logic        clk_i, reset_n_i, cyc, stb, we, ack, run, rev, inch, heat, frst, dig, slow;
  logic        run_o, rev_o, zh, inch_o, dst, dsp, stp, act, up, pv;
  logic [7:0]  adr, car;
  logic [1:0]  res;
  logic [31:0] dat, rdo, dout;
  logic [15:0] tgt, rfo, ia, id, rf, pexp;
  int          failures, n_compared, k, m[int];
  int          cv[4] = '{4, 5, 160, 161};
  int          tv[6] = '{1050, 1100, 950, 2950, 3060, 40000};

  dfa_core #(.TICK_CYCLES(TK)) DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(dout), .wb_ack_o(ack), .run_cmd_i(run), .reverse_cmd_i(rev),
    .inch_cmd_i(inch), .heat_high_i(heat), .fault_reset_i(frst), .digital_src_i(dig),
    .drive_stopped_i(stp), .ramp_active_i(act), .ramp_up_i(up), .ramp_freq_i(rf),
    .run_o(run_o), .reverse_o(rev_o), .zero_hold_o(zh), .inch_active_o(inch_o),
    .direct_start_o(dst), .decel_stop_o(dsp), .target_freq_o(tgt), .running_freq_o(rfo),
    .inch_accel_o(ia), .inch_decel_o(id), .carrier_rate_o(car), .freq_res_o(res));
  dfa_ramp_model PM (.clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run_o), .slow_i(slow),
    .target_i(tgt), .stopped_o(stp), .active_o(act), .up_o(up), .freq_o(rf));

  // ---------------------------------------------------------------
  // model and bus tasks
  // ---------------------------------------------------------------
  // md 0 nearest edge, 1 upper edge, 2 lower edge
  function automatic int skf(input int f, input int md);
    int lo, hi;
    if (m[8'h20] == 0 && m[8'h24] == 0) return f;
    for (int i = 0; i < 2; i++) begin
      lo = m[8'h20 + 4 * i] - m[8'h28];
      hi = m[8'h20 + 4 * i] + m[8'h28];
      if (f > lo && f < hi) return md == 1 ? hi : md == 2 ? lo : (f - lo <= hi - f) ? lo : hi;
    end
    return f;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic settle;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic idle;
    k = 0;
    repeat (3) @(posedge clk_i);
    while (act !== 1'b0 && k < 900) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 900) failures++;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    // no limit here: the watchdog ends a bus that never answers
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdo = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    int v;
    v = d;
    case (a)
      dfa_pkg::OFS_CTRL: v = (d[6:5] == 0 || d[6:5] == 3) ? (m[a] & 'h60) | (d & 'h1F)
                                                          : d & 'h7F;
      dfa_pkg::OFS_CARR: if (d < 5 || d > 160) v = m[a];
      dfa_pkg::OFS_DEAD: if (d > 30000) v = 30000;
      dfa_pkg::OFS_INCHA, dfa_pkg::OFS_INCHD: if (d > 65000) v = 65000;
      default: if (d > 32000) v = 32000;
    endcase
    m[a] = v;
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 0);
    chk("read", m[a], rdo);
  endtask
  task automatic do_reset;
    // model filled first so the monitor never reads a missing entry
    for (int i = 0; i <= 56; i += 4) m[i] = 0;
    m[0] = 8'h42;
    m[8'h10] = 8'h28;
    m[8'h34] = 8'h28;
    m[8'h14] = 200;
    m[8'h18] = 200;
    m[8'h1C] = 200;
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
  endtask
  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, monitor, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (pv) chk("running", pexp, rfo);
    pexp = (m[0][4] && act) ? skf(rf, up ? 1 : 2) : rf;
    pv   = reset_n_i;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {cyc, stb, we, run, rev, inch, heat, frst, slow, pv} = 10'h000;
    {reset_n_i, adr, dat, dig} = 42'h001;
    void'($urandom(55));
    do_reset();
    for (int a = 0; a <= 56; a += 4) if (a != 44) rd(a);
    chk("carrier", 8'h28, car);
    chk("res", 2'h2, res);
    for (int a = 4; a <= 40; a += 4) begin
      // skip points and amplitude land clamped at the cap: both bands coincide as one wide band
      wr(a, $urandom_range(a < 32 ? 0 : 32001, 65535));
      rd(a);
    end
    wr(dfa_pkg::OFS_INCHA, 65535);
    rd(dfa_pkg::OFS_INCHA);
    foreach (cv[i]) begin
      wr(dfa_pkg::OFS_CARR, cv[i]);
      settle();
      chk("carrier", m[8'h10], car);
    end
    heat <= 1'b1;
    settle();
    chk("hot carrier", 8'h50, car);
    wr(dfa_pkg::OFS_CARR, 9);
    settle();
    chk("hot floor", 8'h05, car);
    heat <= 1'b0;
    settle();
    chk("restored", 8'h09, car);
    wr(0, 8'h40);
    heat <= 1'b1;
    settle();
    chk("no adjust", 8'h09, car);
    heat <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(0, ((c * 3 + 1) % 4) * 32);
      settle();
      chk("res", m[0] >> 5, res);
    end
    run <= 1'b1;
    wr(dfa_pkg::OFS_SKAMP, 100);
    wr(dfa_pkg::OFS_SKIP1, 1000);
    wr(dfa_pkg::OFS_SKIP2, 3000);
    for (int i = 0; i < 14; i++) begin
      wr(dfa_pkg::OFS_SETF, i < 6 ? tv[i] : $urandom_range(0, 4000));
      settle();
      chk("target", skf(m[8'h08], 0), tgt);
    end
    wr(dfa_pkg::OFS_SKIP1, 0);
    wr(dfa_pkg::OFS_SKIP2, 0);
    wr(dfa_pkg::OFS_SETF, 1050);
    settle();
    chk("no skip", 1050, tgt);
    wr(dfa_pkg::OFS_SKIP1, 1000);
    wr(dfa_pkg::OFS_SKIP2, 3000);
    idle();
    wr(0, 8'h50);
    wr(dfa_pkg::OFS_SETF, 4000);
    idle();
    slow <= 1'b1;
    wr(dfa_pkg::OFS_SETF, 500);
    idle();
    slow <= 1'b0;
    wr(dfa_pkg::OFS_DEAD, 2);
    rev <= 1'b1;
    k = 0;
    while (zh !== 1'b1 && k < 10) begin
      @(posedge clk_i);
      k++;
    end
    k = 0;
    while (zh === 1'b1 && k < 40) begin
      @(posedge clk_i);
      k++;
      if (k == 3) chk("hold target", 0, tgt);
    end
    chk("dead span", 1, k >= 2 * TK - 1 && k <= 2 * TK + 2);
    settle();
    chk("reverse", 1, rev_o);
    wr(dfa_pkg::OFS_DEAD, 0);
    rev <= 1'b0;
    k = 0;
    repeat (8) begin
      @(posedge clk_i);
      if (zh === 1'b1) k++;
    end
    chk("no hold", 0, k);
    chk("forward", 0, rev_o);
    wr(dfa_pkg::OFS_INCHF, 200);
    inch <= 1'b1;
    settle();
    chk("inch blocked", 0, inch_o);
    wr(0, 8'h58);
    settle();
    chk("inch prio", {3'h7, 16'd200}, {inch_o, dst, dsp, tgt});
    chk("inch times", {m[8'h18][15:0], m[8'h1C][15:0]}, {ia, id});
    {run, inch} <= 2'h0;
    wr(0, 8'h50);
    idle();
    inch <= 1'b1;
    settle();
    chk("inch stop", 2'h3, {inch_o, run_o});
    inch <= 1'b0;
    idle();
    for (int i = 0; i < 3; i++) begin
      wr(0, i == 1 ? 8'h41 : 8'h40);
      dig <= i != 2;
      wr(dfa_pkg::OFS_PRESET, 500);
      wr(dfa_pkg::OFS_SETF, 1500);
      run <= 1'b1;
      settle();
      run <= 1'b0;
      idle();
      settle();
      if (i == 0) m[8'h08] = 500;
      rd(dfa_pkg::OFS_SETF);
    end
    run <= 1'b1;
    do_reset();
    wr(0, 8'h46);
    settle();
    chk("power lock", 0, run_o);
    run <= 1'b0;
    settle();
    run <= 1'b1;
    settle();
    chk("rearmed", 1, run_o);
    frst <= 1'b1;
    @(posedge clk_i);
    frst <= 1'b0;
    settle();
    chk("fault lock", 0, run_o);
    run <= 1'b0;
    settle();
    run <= 1'b1;
    settle();
    chk("unlocked", 1, run_o);
    complete_run();
  end
endmodule
